// ### design/charge_prescaler.sv
// Up/down prescaler between the analog integrator ticks and the accumulator.
// Assumes tick inputs are one-cycle pulses synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none

module charge_prescaler (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    input  wire logic [2:0] code,
    input  wire logic       clear,
    input  wire logic       up,
    input  wire logic       dn,
    output var  logic       ovf,
    output var  logic       unf
);

    logic [gauge_pkg::PRE_CNT_W-1:0] count;
    logic [gauge_pkg::PRE_CNT_W-1:0] next_count;
    logic [gauge_pkg::PRE_CNT_W-1:0] limit;
    logic                            at_top;
    logic                            at_bottom;
    logic                            step_up;
    logic                            step_dn;

    assign limit     = gauge_pkg::prescale_factor(code) - gauge_pkg::PRE_CNT_W'(1);
    assign at_top    = count >= limit;
    assign at_bottom = count == '0;
    assign step_up   = up && !dn && !clear;
    assign step_dn   = dn && !up && !clear;

    assign next_count = clear   ? '0 :
                        step_up ? (at_top ? '0 : count + gauge_pkg::PRE_CNT_W'(1)) :
                        step_dn ? (at_bottom ? limit : count - gauge_pkg::PRE_CNT_W'(1)) :
                                  count;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
            ovf   <= 1'b0;
            unf   <= 1'b0;
        end else if (clk_en) begin
            count <= next_count;
            ovf   <= step_up && at_top;
            unf   <= step_dn && at_bottom;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_pre_wrap;
        clk_en && step_up && count == limit |=> ovf && count == '0;
    endproperty
    a_pre_wrap: assert property (p_pre_wrap) else $error("prescaler did not wrap at its factor");

    property p_pre_clear;
        clk_en && clear |=> count == '0 && !ovf && !unf;
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("prescaler kept fraction in shutdown");

endmodule

`default_nettype wire

// ### design/gauge_control_register.sv
// Control register of the battery gas gauge, converter sequencer, alert pin
// logic and charge accumulator. Assumes the serial-bus front end delivers
// register writes as one-cycle strobes and the analog side delivers integrator
// ticks, conversion-done and limit events as one-cycle pulses on ref_clk.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Mode field: 11 continuous, 10 every 10 s, 01 once, 00 sleep.
// - Prescale field resets to 111; codes 110 and 111 give 4096.
// - Prescale codes 000 to 110 divide by four to the code.
// - Pin field resets to 10, alert mode, open-drain active-low output.
// - Alert mode pulls pin low on any limit or accumulator wrap.
// - A completed alert response from the master releases the pin.
// - Changing pin field during an alert keeps pin low until response.
// - Pin field 01: low pin input loads accumulator with FFFFh.
// - Pin field 00: no alert drive and no charge-complete input.
// - Shutdown stops integration; accumulator ignores charge meanwhile.
// - Bus and register contents stay alive through shutdown.
// - Entering shutdown drops the prescaler's fractional count.
// - Shutdown bit resets to 0 so integration runs after power-on.
// - Prescaler overflow increments accumulator, underflow decrements it.
// - Single conversion set ends by writing mode field back to 00.
module gauge_control_register #(
    parameter int unsigned SCAN_CYCLES = gauge_pkg::SCAN_CYCLES
) (
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    input  wire logic             clk_en,
    input  wire logic             ctrl_wr,
    input  wire gauge_pkg::ctrl_s ctrl_wr_data,
    output var  gauge_pkg::ctrl_s control,
    input  wire logic             acr_wr,
    input  wire logic [15:0]      acr_wr_data,
    output var  logic [15:0]      charge_accumulator,
    input  wire logic             integ_up,
    input  wire logic             integ_dn,
    input  wire logic             conv_done,
    input  wire logic             limit_event,
    input  wire logic             ara_done,
    output var  logic             conv_start,
    output var  logic             analog_on,
    output var  logic             acr_wrapped,
    input  wire logic             alert_or_charge_done_pin_in,
    output var  logic             alert_or_charge_done_pin_out,
    output var  logic             alert_or_charge_done_pin_oe
);

    typedef enum logic [1:0] { CV_IDLE, CV_BUSY, CV_WAIT } conv_state_e;

    localparam int CNT_W = $clog2(SCAN_CYCLES + 1);

    conv_state_e      state;
    conv_state_e      next_state;
    logic [1:0]       run_mode;
    logic [CNT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] next_wait_cnt;
    gauge_pkg::ctrl_s next_control;
    logic [15:0]      next_acr;
    logic             pf_ovf;
    logic             pf_unf;
    logic             alert_en;
    logic             charge_en;
    logic             full_load;
    logic             count_up;
    logic             count_dn;
    logic             wrap_evt;
    logic             alert_set;
    logic             start_now;
    logic             single_end;

    assign alert_en  = control.pin_func[1];
    assign charge_en = control.pin_func[0];

    charge_prescaler u_prescaler (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .code    (control.prescale),
        .clear   (control.shutdown),
        .up      (integ_up && !control.shutdown),
        .dn      (integ_dn && !control.shutdown),
        .ovf     (pf_ovf),
        .unf     (pf_unf)
    );

    assign full_load = charge_en && !alert_or_charge_done_pin_in && !alert_or_charge_done_pin_oe;
    assign count_up  = pf_ovf && !control.shutdown;
    assign count_dn  = pf_unf && !control.shutdown;
    assign wrap_evt  = (count_up && charge_accumulator == 16'hFFFF)
                    || (count_dn && charge_accumulator == 16'h0000);

    assign next_acr = acr_wr    ? acr_wr_data :
                      full_load ? gauge_pkg::ACR_FULL :
                      count_up  ? charge_accumulator + 16'h0001 :
                      count_dn  ? charge_accumulator - 16'h0001 :
                                  charge_accumulator;

    assign alert_set = alert_en && (limit_event || wrap_evt);

    assign start_now  = state == CV_IDLE && control.adc_mode != gauge_pkg::MODE_SLEEP && !control.shutdown;
    assign single_end = state == CV_BUSY && conv_done && run_mode == gauge_pkg::MODE_SINGLE;

    always_comb begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        case (state)
            CV_IDLE: begin
                if (start_now) begin
                    next_state = CV_BUSY;
                end
            end
            CV_BUSY: begin
                if (conv_done) begin
                    if (control.adc_mode == gauge_pkg::MODE_SCAN && !single_end) begin
                        next_state    = CV_WAIT;
                        next_wait_cnt = CNT_W'(SCAN_CYCLES);
                    end else begin
                        next_state = CV_IDLE;
                    end
                end
            end
            CV_WAIT: begin
                if (control.adc_mode != gauge_pkg::MODE_SCAN || wait_cnt <= CNT_W'(1)) begin
                    next_state    = CV_IDLE;
                    next_wait_cnt = '0;
                end else begin
                    next_wait_cnt = wait_cnt - CNT_W'(1);
                end
            end
            default: begin
                next_state = CV_IDLE;
            end
        endcase
    end

    always_comb begin
        next_control = control;
        if (ctrl_wr) begin
            next_control = ctrl_wr_data;
        end else if (single_end) begin
            next_control.adc_mode = gauge_pkg::MODE_SLEEP;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            control            <= gauge_pkg::CTRL_RESET;
            charge_accumulator <= gauge_pkg::ACR_RESET;
            state              <= CV_IDLE;
            run_mode           <= gauge_pkg::MODE_SLEEP;
            wait_cnt           <= '0;
            conv_start         <= 1'b0;
            analog_on          <= 1'b1;
            acr_wrapped        <= 1'b0;
        end else if (clk_en) begin
            control            <= next_control;
            charge_accumulator <= next_acr;
            state              <= next_state;
            run_mode           <= start_now ? control.adc_mode : run_mode;
            wait_cnt           <= next_wait_cnt;
            conv_start         <= start_now;
            analog_on          <= !next_control.shutdown;
            acr_wrapped        <= wrap_evt && !acr_wr && !full_load;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            alert_or_charge_done_pin_oe  <= 1'b0;
            alert_or_charge_done_pin_out <= 1'b0;
        end else if (clk_en) begin
            alert_or_charge_done_pin_oe  <= alert_set || (alert_or_charge_done_pin_oe && !ara_done);
            alert_or_charge_done_pin_out <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_alert_set;
        clk_en && alert_en && limit_event |=> alert_or_charge_done_pin_oe && !alert_or_charge_done_pin_out;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("alert did not pull pin low");

    property p_alert_hold;
        alert_or_charge_done_pin_oe && !(clk_en && ara_done) |=> alert_or_charge_done_pin_oe;
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("pin released without alert response");

    property p_ara_release;
        clk_en && ara_done && !alert_set |=> !alert_or_charge_done_pin_oe;
    endproperty
    a_ara_release: assert property (p_ara_release) else $error("pin held after alert response");

    property p_full_load;
        clk_en && charge_en && !alert_or_charge_done_pin_in && !alert_or_charge_done_pin_oe && !acr_wr
            |=> charge_accumulator == gauge_pkg::ACR_FULL;
    endproperty
    a_full_load: assert property (p_full_load) else $error("charge complete did not load full scale");

    property p_pin_off;
        clk_en && control.pin_func == gauge_pkg::PIN_OFF && !alert_or_charge_done_pin_oe && !acr_wr && !count_up
            && !count_dn |=> charge_accumulator == $past(charge_accumulator) && !alert_or_charge_done_pin_oe;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("disabled pin acted");

    property p_shutdown_hold;
        clk_en && control.shutdown && !acr_wr && !full_load |=> charge_accumulator == $past(charge_accumulator);
    endproperty
    a_shutdown_hold: assert property (p_shutdown_hold) else $error("accumulator moved in shutdown");

    property p_regs_kept;
        clk_en && control.shutdown && !ctrl_wr && !single_end |=> control == $past(control);
    endproperty
    a_regs_kept: assert property (p_regs_kept) else $error("control changed in shutdown");

    property p_acr_step;
        clk_en && count_up && !acr_wr && !full_load |=> charge_accumulator == $past(charge_accumulator) + 16'h0001;
    endproperty
    a_acr_step: assert property (p_acr_step) else $error("accumulator missed prescaler overflow");

    property p_single_clear;
        clk_en && single_end && !ctrl_wr |=> control.adc_mode == gauge_pkg::MODE_SLEEP && state == CV_IDLE;
    endproperty
    a_single_clear: assert property (p_single_clear) else $error("single mode not cleared");

    property p_start;
        clk_en && start_now |=> conv_start && state == CV_BUSY;
    endproperty
    a_start: assert property (p_start) else $error("conversion not started");

endmodule

`default_nettype wire

// ### design/gauge_pkg.sv
// Shared constants and types of the gas-gauge control register block.
// Assumes a single 10 MHz clock domain and an active-low asynchronous reset.
package gauge_pkg;

    // Clock rate and scan-mode sleep time.
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned SCAN_PERIOD_S  = 10;
    localparam int unsigned SCAN_CYCLES    = SCAN_PERIOD_S * CLK_HZ;

    // Control register field positions.
    localparam int MODE_MSB  = 7;
    localparam int MODE_LSB  = 6;
    localparam int PRE_MSB   = 5;
    localparam int PRE_LSB   = 3;
    localparam int PIN_MSB   = 2;
    localparam int PIN_LSB   = 1;
    localparam int SHDN_BIT  = 0;

    // Converter mode codes.
    localparam logic [1:0] MODE_SLEEP  = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_SCAN   = 2'h2;
    localparam logic [1:0] MODE_AUTO   = 2'h3;

    // Pin-function codes; bit 1 enables alert output, bit 0 charge-complete input.
    localparam logic [1:0] PIN_OFF     = 2'h0;
    localparam logic [1:0] PIN_CHARGE  = 2'h1;
    localparam logic [1:0] PIN_ALERT   = 2'h2;

    // Reset values.
    localparam logic [1:0]  MODE_RESET = MODE_SLEEP;
    localparam logic [2:0]  PRE_RESET  = 3'h7;
    localparam logic [1:0]  PIN_RESET  = PIN_ALERT;
    localparam logic        SHDN_RESET = 1'b0;
    localparam logic [15:0] ACR_RESET  = 16'h7FFF;
    localparam logic [15:0] ACR_FULL   = 16'hFFFF;

    // Prescaler sizing; the largest factor is 4096.
    localparam int          PRE_CNT_W  = 13;
    localparam logic [2:0]  PRE_CAP    = 3'h6;

    typedef struct packed {
        logic [1:0] adc_mode;
        logic [2:0] prescale;
        logic [1:0] pin_func;
        logic       shutdown;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = '{MODE_RESET, PRE_RESET, PIN_RESET, SHDN_RESET};

    // Division factor four to the power of the code, capped at code 6.
    function automatic logic [PRE_CNT_W-1:0] prescale_factor(input logic [2:0] code);
        logic [2:0] eff;
        eff = (code > PRE_CAP) ? PRE_CAP : code;
        prescale_factor = PRE_CNT_W'(1) << (2 * eff);
    endfunction

endpackage

// ### tb/charger_model.sv
// Behavioural charger on the dual-purpose gauge pin, plus the board pull-up.
// Assumes the gauge's output enable is high while it pulls the pin low.
`timescale 1ns/1ns
`default_nettype none

module charger_model (
    input  wire logic ref_clk,
    input  wire logic full_req,
    input  wire logic pin_oe,
    input  wire logic pin_out,
    output var  logic pin_level
);
    logic charger_low = 1'b0;

    always @(posedge ref_clk) begin
        charger_low <= full_req;
    end

    // Open-drain wire: any party may pull it low, otherwise the pull-up wins.
    assign pin_level = ((pin_oe && !pin_out) || charger_low) ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the gauge control register block.
// Assumes the charger model and the design package are compiled first.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    typedef struct packed {
        logic [2:0]  code;
        logic        dn;
        logic [12:0] n;
    } row_s;

    localparam logic [4:0] UP = 5'h01, DN = 5'h02, DONE = 5'h04, LIMIT = 5'h08, ARA = 5'h10;

    logic             ref_clk, rstn, clk_en, ctrl_wr, acr_wr, full_req, pin_level;
    logic [4:0]       ev;
    gauge_pkg::ctrl_s ctrl_wr_data, control;
    logic [15:0]      acr_wr_data, charge_accumulator;
    logic             conv_start, analog_on, pin_out, pin_oe, acr_wrapped;
    int               fails, check_count, cycles, n, m;
    logic [15:0]      exp_acc;
    row_s             rows [8] = '{'{3'h0, 1'b0, 13'h0001}, '{3'h1, 1'b0, 13'h0003}, '{3'h1, 1'b0, 13'h0004},
                                  '{3'h2, 1'b1, 13'h0011}, '{3'h3, 1'b0, 13'h0040}, '{3'h5, 1'b1, 13'h0001},
                                  '{3'h6, 1'b0, 13'h1000}, '{3'h7, 1'b0, 13'h0FFF}};

    gauge_control_register #(.SCAN_CYCLES(20)) DUT (
        .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .ctrl_wr(ctrl_wr), .ctrl_wr_data(ctrl_wr_data),
        .control(control), .acr_wr(acr_wr), .acr_wr_data(acr_wr_data), .charge_accumulator(charge_accumulator),
        .integ_up(ev[0]), .integ_dn(ev[1]), .conv_done(ev[2]), .limit_event(ev[3]), .ara_done(ev[4]),
        .conv_start(conv_start), .analog_on(analog_on), .acr_wrapped(acr_wrapped),
        .alert_or_charge_done_pin_in(pin_level), .alert_or_charge_done_pin_out(pin_out),
        .alert_or_charge_done_pin_oe(pin_oe)
    );

    charger_model partner (
        .ref_clk(ref_clk), .full_req(full_req), .pin_oe(pin_oe), .pin_out(pin_out), .pin_level(pin_level)
    );

    function automatic gauge_pkg::ctrl_s mk(input logic [1:0] md, input logic [2:0] c, input logic [1:0] p,
                                            input logic sd);
        mk = '{md, c, p, sd};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic pulse(input logic [4:0] p, input int k);
        repeat (k) begin
            @(posedge ref_clk);
            ev <= p;
        end
        @(posedge ref_clk);
        ev <= 5'h00;
        #1;
    endtask

    task automatic wr_ctrl(input gauge_pkg::ctrl_s d);
        @(posedge ref_clk);
        ctrl_wr      <= 1'b1;
        ctrl_wr_data <= d;
        @(posedge ref_clk);
        ctrl_wr <= 1'b0;
        #1;
        check("control", control, d);
    endtask

    task automatic wr_acr(input logic [15:0] d);
        @(posedge ref_clk);
        acr_wr      <= 1'b1;
        acr_wr_data <= d;
        @(posedge ref_clk);
        acr_wr <= 1'b0;
        #1;
    endtask

    task automatic wait_start(output int k);
        k = 0;
        do begin
            step(1);
            k++;
        end while (conv_start !== 1'b1 && k < 100);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        {rstn, ctrl_wr, acr_wr, full_req, ev, acr_wr_data} = '0;
        clk_en       = 1'b1;
        ctrl_wr_data = gauge_pkg::CTRL_RESET;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        step(1);
        check("reset control", control, 8'h3C);
        check("reset acc", charge_accumulator, gauge_pkg::ACR_RESET);
        check("reset analog", analog_on, 1'b1);
        check("reset pin", pin_oe, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            m = 4 ** ((rows[i].code > 3'h6) ? 6 : rows[i].code);
            exp_acc = rows[i].dn ? 16'h1000 - 16'((int'(rows[i].n) + m - 1) / m) : 16'h1000 + 16'(int'(rows[i].n) / m);
            wr_ctrl(mk(gauge_pkg::MODE_SLEEP, rows[i].code, gauge_pkg::PIN_OFF, 1'b1));
            wr_acr(16'h1000);
            wr_ctrl(mk(gauge_pkg::MODE_SLEEP, rows[i].code, gauge_pkg::PIN_OFF, 1'b0));
            pulse(rows[i].dn ? DN : UP, rows[i].n);
            step(3);
            check("prescaled acc", charge_accumulator, exp_acc);
        end
        $display("test prescale rows done");
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h1, gauge_pkg::PIN_OFF, 1'b1));
        wr_acr(16'h0200);
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h1, gauge_pkg::PIN_OFF, 1'b0));
        pulse(UP, 3);
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h1, gauge_pkg::PIN_OFF, 1'b1));
        pulse(UP, 5);
        step(3);
        check("shutdown acc", charge_accumulator, 16'h0200);
        check("shutdown analog", analog_on, 1'b0);
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h1, gauge_pkg::PIN_OFF, 1'b0));
        pulse(UP, 1);
        step(3);
        check("fraction lost", charge_accumulator, 16'h0200);
        pulse(UP, 3);
        step(3);
        check("after shutdown", charge_accumulator, 16'h0201);
        $display("test shutdown done");
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h0, gauge_pkg::PIN_ALERT, 1'b0));
        pulse(LIMIT, 1);
        step(1);
        check("limit alert", pin_level, 1'b0);
        check("pin drive", pin_out, 1'b0);
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h0, gauge_pkg::PIN_OFF, 1'b0));
        check("alert kept", pin_oe, 1'b1);
        pulse(ARA, 1);
        step(1);
        check("alert cleared", pin_oe, 1'b0);
        pulse(LIMIT, 1);
        step(1);
        check("pin off alert", pin_oe, 1'b0);
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h0, gauge_pkg::PIN_ALERT, 1'b1));
        wr_acr(16'hFFFF);
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h0, gauge_pkg::PIN_ALERT, 1'b0));
        pulse(UP, 1);
        step(1);
        check("wrap flag", acr_wrapped, 1'b1);
        step(2);
        check("wrap acc", charge_accumulator, 16'h0000);
        check("wrap alert", pin_oe, 1'b1);
        check("wrap flag end", acr_wrapped, 1'b0);
        pulse(ARA, 1);
        $display("test alert done");
        // the pin field is never given code 11
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h0, gauge_pkg::PIN_OFF, 1'b0));
        @(posedge ref_clk);
        full_req <= 1'b1;
        step(4);
        check("pin off input", charge_accumulator, 16'h0000);
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h0, gauge_pkg::PIN_CHARGE, 1'b0));
        step(2);
        check("charge full", charge_accumulator, gauge_pkg::ACR_FULL);
        @(posedge ref_clk);
        full_req <= 1'b0;
        $display("test charge complete done");
        wr_ctrl(mk(gauge_pkg::MODE_SINGLE, 3'h7, gauge_pkg::PIN_OFF, 1'b0));
        wait_start(n);
        check("single start", n <= 3, 1'b1);
        pulse(DONE, 1);
        step(1);
        check("single clear", control, mk(gauge_pkg::MODE_SLEEP, 3'h7, gauge_pkg::PIN_OFF, 1'b0));
        wr_ctrl(mk(gauge_pkg::MODE_AUTO, 3'h7, gauge_pkg::PIN_OFF, 1'b0));
        wait_start(n);
        pulse(DONE, 1);
        wait_start(n);
        check("auto restart", n <= 3, 1'b1);
        wr_ctrl(mk(gauge_pkg::MODE_SCAN, 3'h7, gauge_pkg::PIN_OFF, 1'b0));
        pulse(DONE, 1);
        wait_start(n);
        check("scan gap", n > 20 && n <= 30, 1'b1);
        wr_ctrl(mk(gauge_pkg::MODE_SLEEP, 3'h7, gauge_pkg::PIN_OFF, 1'b0));
        pulse(DONE, 1);
        step(2);
        $display("test converter done");
        wr_ctrl(mk(gauge_pkg::MODE_SCAN, 3'h2, gauge_pkg::PIN_CHARGE, 1'b1));
        @(posedge ref_clk);
        rstn <= 1'b0;
        step(2);
        check("reset hold", control, 8'h3C);
        @(posedge ref_clk);
        rstn <= 1'b1;
        step(1);
        check("rerun control", control, 8'h3C);
        check("rerun analog", analog_on, 1'b1);
        check("rerun acc", charge_accumulator, gauge_pkg::ACR_RESET);
        $display("test reset again done");
        close_out();
    end
endmodule

`default_nettype wire
